/* verilog/owl_cfg.svh */
// Purpose: Timing, packet layout and field constants for the sensor link
// Assumes: 100 MHz clock; times are given in nanoseconds
// Notes:   Cycle counts are derived in the link module from these figures
`ifndef OWL_CFG_SVH
`define OWL_CFG_SVH

`define OWL_CLK_NS         10
// Least high time of a host forced start (force_high_time)
`define OWL_FORCE_HIGH_NS  120000
// Least low hold that terminates or cancels a readout
`define OWL_TERM_LOW_NS    160000
// Interval of sensor-raised starts in interrupt mode (sample_period)
`define OWL_SAMPLE_NS      16000000
// Time the device holds its answer for one bit (bit_settle_time window)
`define OWL_ANSWER_NS      10000

`define OWL_PKT_W          40
`define OWL_ADC_W          14
`define OWL_CFG_W          25
`define OWL_MODE_LSB       7
`define OWL_CNT_W          21
`define OWL_IDX_W          6
`define OWL_IDX_LAST       6'h27

`endif

/* verilog/owl_pkg.sv */
// Purpose: Types shared by the sensor link design
// Assumes: owl_cfg.svh supplies the widths
// Notes:   State, mode, pin and packet carriers live here
`include "owl_cfg.svh"

package owl_pkg;

  typedef enum logic [1:0] {
    OWL_MODE_FORCED = 2'h0,
    OWL_MODE_INTR   = 2'h1,
    OWL_MODE_WAKE   = 2'h2,
    OWL_MODE_RSVD   = 2'h3
  } owl_mode_e;

  typedef enum logic [1:0] {
    OWL_ST_IDLE  = 2'h0,
    OWL_ST_RAISE = 2'h1,
    OWL_ST_BIT   = 2'h2,
    OWL_ST_ANS   = 2'h3
  } owl_state_e;

  typedef struct packed {
    logic o;
    logic oe;
  } owl_pin_s;

  typedef struct packed {
    logic                   in_range;
    logic [`OWL_ADC_W-1:0]  adc;
    logic [`OWL_CFG_W-1:0]  cfg;
  } owl_pkt_s;

  typedef struct packed {
    owl_state_e             state;
    logic                   sync1;
    logic                   sync2;
    logic                   line_p;
    logic [`OWL_CNT_W-1:0]  cnt;
    logic [`OWL_CNT_W-1:0]  tmr;
    logic [`OWL_PKT_W-1:0]  shreg;
    logic [`OWL_IDX_W-1:0]  idx;
    logic                   last;
    logic                   alarm;
    owl_pin_s               pin;
    logic                   term;
    logic                   full;
  } owl_st_s;

endpackage : owl_pkg

/* verilog/owl_link.sv */
// Purpose: Device end of the one-wire readout and interrupt link
// Assumes: Wire resolves as: any low driver wins, else any high driver,
//          else a weak pull-down gives low
// Notes:   Sensor core values are sampled at each start of a readout
// Behaviour
// - Every exchange starts with a low-to-high transition of the line.
// - Mode decides the starter: host in forced mode, sensor in interrupt mode.
// - Wake-up: sensor raises line on motion and keeps it high.
// - Interrupt mode: sensor raises line every 16 ms; host pulls low.
// - Host raises then releases; sensor pulls low for 0, holds high for 1.
// - A 160 us low hold at any bit ends the readout.
// - Packet: bit 39 range flag, 38..25 conversion, 24..0 configuration.
// - Mode field: 0 forced, 1 interrupt, 2 wake-up, 3 reserved.
`timescale 1ns/1ps
`include "owl_cfg.svh"

module owl_link
  import owl_pkg::*;
#(
  parameter int FORCE_CYC  = (`OWL_FORCE_HIGH_NS + `OWL_CLK_NS - 1)
                             / `OWL_CLK_NS,
  parameter int TERM_CYC   = (`OWL_TERM_LOW_NS + `OWL_CLK_NS - 1)
                             / `OWL_CLK_NS,
  parameter int SAMPLE_CYC = `OWL_SAMPLE_NS / `OWL_CLK_NS
)(
  input  wire logic     clk,        // 100 MHz system clock
  input  wire logic     nrst,       // Asynchronous reset, active low
  input  wire logic     line,       // Level seen on the shared line
  output owl_pin_s      line_pin,   // Line drive value and enable
  input  wire owl_pkt_s pkt,        // Range flag, conversion, config
  input  wire logic     motion,     // Motion detector fired, pulse
  output logic          alarm,      // Wake-up alarm pending
  output logic          term,       // Readout terminated, pulse
  output logic          full        // Whole packet was read, pulse
);

  localparam int ANS_CYC = `OWL_ANSWER_NS / `OWL_CLK_NS;

  logic [1:0] rst_sync_q;
  logic       rst_n;
  owl_st_s    q;
  owl_st_s    d;
  owl_mode_e  mode;
  logic       line_s;
  logic       rise;
  logic       fall;
  logic       tick;
  logic       load;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'h1};
  end
  assign rst_n = rst_sync_q[1];

  assign mode   = owl_mode_e'(pkt.cfg[`OWL_MODE_LSB +: 2]);
  assign line_s = q.sync2;
  assign rise   = line_s & ~q.line_p;
  assign fall   = ~line_s & q.line_p;

  always_comb
  begin
    d        = q;
    d.sync1  = line;
    d.sync2  = q.sync1;
    d.line_p = line_s;
    d.term   = 1'h0;
    d.full   = 1'h0;
    tick     = 1'h0;
    load     = 1'h0;
    // Free-running timebase for the periodic interrupt start
    if (q.tmr >= `OWL_CNT_W'(SAMPLE_CYC - 1))
    begin
      d.tmr = '0;
      tick  = 1'h1;
    end
    else
      d.tmr = q.tmr + 1'h1;
    case (q.state)
      OWL_ST_IDLE:
      begin
        d.pin = '0;
        if (!line_s)
          d.cnt = '0;
        else if (q.cnt < `OWL_CNT_W'(FORCE_CYC))
          d.cnt = q.cnt + 1'h1;
        case (mode)
          OWL_MODE_FORCED:
            // Host high for the force time, then low, opens the readout
            if (fall && q.cnt >= `OWL_CNT_W'(FORCE_CYC))
            begin
              load    = 1'h1;
              d.cnt   = '0;
              d.state = OWL_ST_BIT;
            end
          OWL_MODE_INTR:
            if (tick)
            begin
              load    = 1'h1;
              d.state = OWL_ST_RAISE;
            end
          OWL_MODE_WAKE:
            if (q.alarm)
            begin
              load    = 1'h1;
              d.state = OWL_ST_RAISE;
            end
          default:
            d.state = OWL_ST_IDLE;
        endcase
      end
      OWL_ST_RAISE:
      begin
        // Hold high until the host pulls low; no self-release
        d.pin = '{o: 1'h1, oe: 1'h1};
        if (fall)
        begin
          d.pin   = '0;
          d.cnt   = '0;
          d.state = OWL_ST_BIT;
        end
      end
      OWL_ST_BIT:
      begin
        d.pin = '0;
        if (line_s)
          d.cnt = '0;
        else
          d.cnt = q.cnt + 1'h1;
        if (rise && !q.last)
        begin
          // MSB first, so bit 0 is the final one shifted out
          d.pin   = '{o: q.shreg[`OWL_PKT_W-1], oe: 1'h1};
          d.cnt   = '0;
          d.state = OWL_ST_ANS;
        end
        else if (!line_s && q.cnt >= `OWL_CNT_W'(TERM_CYC - 1))
        begin
          d.term  = 1'h1;
          d.full  = q.last;
          d.alarm = 1'h0;
          d.cnt   = '0;
          d.state = OWL_ST_IDLE;
        end
      end
      OWL_ST_ANS:
      begin
        // Answer is released in time for the host's next rising edge
        d.cnt = q.cnt + 1'h1;
        if (q.cnt >= `OWL_CNT_W'(ANS_CYC - 1))
        begin
          d.pin   = '0;
          d.cnt   = '0;
          d.shreg = {q.shreg[`OWL_PKT_W-2:0], 1'h0};
          d.last  = (q.idx == '0);
          d.idx   = q.idx - 1'h1;
          d.state = OWL_ST_BIT;
        end
      end
      default:
        d.state = OWL_ST_IDLE;
    endcase
    if (load)
    begin
      d.shreg = pkt;
      d.idx   = `OWL_IDX_LAST;
      d.last  = 1'h0;
    end
    // A motion event in the clearing cycle still counts
    if (motion && mode == OWL_MODE_WAKE)
      d.alarm = 1'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign line_pin = q.pin;
  assign alarm    = q.alarm;
  assign term     = q.term;
  assign full     = q.full;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_forced_start: assert property (
    q.state == OWL_ST_IDLE && d.state == OWL_ST_BIT
    |-> q.cnt >= `OWL_CNT_W'(FORCE_CYC) && q.line_p && !line_s)
    else $error("readout opened without a qualified start");

  a_forced_quiet: assert property (
    mode == OWL_MODE_FORCED && q.state == OWL_ST_IDLE |-> !q.pin.oe)
    else $error("device drove the line in forced idle");

  a_wake_hold: assert property (
    q.state == OWL_ST_RAISE && line_s
    |=> q.state == OWL_ST_RAISE && q.pin.oe && q.pin.o)
    else $error("raised line dropped without host pull");

  a_intr_raise: assert property (
    mode == OWL_MODE_INTR && q.state == OWL_ST_IDLE && tick
    |=> ##1 q.state == OWL_ST_RAISE && q.pin.oe && q.pin.o)
    else $error("periodic start not raised");

  a_bit_answer: assert property (
    q.state == OWL_ST_BIT && rise && !q.last
    |=> q.pin.oe && q.pin.o == $past(q.shreg[`OWL_PKT_W-1]))
    else $error("bit answer does not match packet");

  a_answer_len: assert property (
    $rose(q.state == OWL_ST_ANS) |-> (q.pin.oe)[*8])
    else $error("bit answer released too early");

  a_abort_end: assert property (
    q.state == OWL_ST_BIT && !line_s && !rise
    && q.cnt == `OWL_CNT_W'(TERM_CYC - 1)
    |=> q.state == OWL_ST_IDLE && term
        && alarm == $past(motion && mode == OWL_MODE_WAKE))
    else $error("low hold did not terminate readout");

  a_packet_load: assert property (
    load |=> q.shreg == $past(pkt) && q.idx == `OWL_IDX_LAST)
    else $error("packet not captured at start");

  a_rsvd_mode: assert property (
    mode == OWL_MODE_RSVD && q.state == OWL_ST_IDLE |=> !q.pin.oe)
    else $error("reserved mode drove the line");

  c_full_read: cover property (full);
  c_intr_start: cover property (
    q.state == OWL_ST_RAISE && mode == OWL_MODE_INTR);
  c_wake_start: cover property (
    q.state == OWL_ST_RAISE && mode == OWL_MODE_WAKE);
  c_abort: cover property (term && !full);

endmodule : owl_link

/* verification/owl_host.sv */
// Purpose: Host controller model on the far side of the sensor link
// Assumes: Bench resolves the wire; caller enters each task at a clk edge
// Notes:   Slots last 1020 cycles so no low phase nears the corruption limit
`timescale 1ns/1ps

module owl_host
  import owl_pkg::*;
(
  input  wire logic clk,   // System clock
  input  wire logic line,  // Resolved line level
  output owl_pin_s  pin    // Host drive value and enable
);
  logic ls1;  // First sync stage of the line
  logic ls2;  // Second sync stage, the only one sampled

  initial pin = '0;

  // The line is asynchronous to the host, so two flops precede sampling
  always @(posedge clk)
  begin
    ls1 <= line;
    ls2 <= ls1;
  end

  task automatic drv(input logic o, input logic oe, input int n);
    pin <= {o, oe};
    repeat (n) @(posedge clk);
  endtask : drv

  task automatic force_start(input int n);
    drv(1'h1, 1'h1, n);
    drv(1'h0, 1'h1, 10);
  endtask : force_start

  // Answer window is fixed, so the next rise waits it out
  task automatic read(input int n, output logic [39:0] v);
    v = '0;
    for (int i = 0; i < n; i++)
    begin
      drv(1'h1, 1'h1, 2);
      drv(1'h0, 1'h0, 28);
      v = {v[38:0], ls2};
      drv(1'h0, 1'h0, 980);
      drv(1'h0, 1'h1, 10);
    end
  endtask : read

  task automatic hold_low(input int n);
    drv(1'h0, 1'h1, n);
    drv(1'h0, 1'h0, 1);
  endtask : hold_low
endmodule : owl_host

/* verification/one_wire_sensor_readout_link_test.sv */
// Purpose: Self-checking bench for the device end of the sensor link
// Assumes: Any low driver wins, else any high driver, else pull-down
// Notes:   Start and hold counts are scaled down by parameters
`timescale 1ns/1ps

module one_wire_sensor_readout_link_test;
  import owl_pkg::*;
  localparam int FC = 20;
  localparam int TC = 30;
  localparam int SC = 200;
  logic        clk, nrst, motion, alarm, term, full, line;
  logic [39:0] v;
  owl_pin_s    dpin, hpin;
  owl_pkt_s    pkt;
  int          errors, compares, n_term, n_full, tm, fm;

  assign line = ((dpin.oe & ~dpin.o) | (hpin.oe & ~hpin.o)) ? 1'h0
              : (dpin.oe | hpin.oe);

  owl_link #(.FORCE_CYC(FC), .TERM_CYC(TC), .SAMPLE_CYC(SC)) i_dut (
    .clk(clk), .nrst(nrst), .line(line), .line_pin(dpin), .pkt(pkt),
    .motion(motion), .alarm(alarm), .term(term), .full(full));
  owl_host i_host (.clk(clk), .line(line), .pin(hpin));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (term === 1'h1) n_term++;
    if (full === 1'h1) n_full++;
  end

  task automatic end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input string nm, input logic [39:0] s, e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic wait_line(input logic lvl, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if (line === lvl) return;
    end
    errors++;
    $display("mismatch line_wait exp %b seen %b", lvl, line);
    end_of_test();
  endtask : wait_line

  task automatic mark;
    tm = n_term;
    fm = n_full;
  endtask : mark

  task automatic t_forced_full;
    mark();
    i_host.force_start(FC + 5);
    check("dev_oe", dpin.oe, 1'h0);
    i_host.read(40, v);
    check("packet", v, pkt);
    i_host.hold_low(TC + 5);
    check("term", n_term - tm, 1);
    check("full", n_full - fm, 1);
    $display("done forced_full");
  endtask : t_forced_full

  task automatic t_abort;
    mark();
    i_host.force_start(FC + 5);
    i_host.read(5, v);
    check("part", v[4:0], pkt[39:35]);
    i_host.hold_low(TC + 5);
    check("term", n_term - tm, 1);
    check("full", n_full - fm, 0);
    $display("done abort");
  endtask : t_abort

  task automatic t_wake;
    pkt.cfg[8:7] <= OWL_MODE_WAKE;
    repeat (20) @(posedge clk);
    motion <= 1'h1;
    @(posedge clk);
    motion <= 1'h0;
    wait_line(1'h1, 10);
    check("alarm", alarm, 1'h1);
    repeat (500) @(posedge clk);
    check("held", line, 1'h1);
    mark();
    i_host.hold_low(TC + 10);
    check("cleared", alarm, 1'h0);
    check("term", n_term - tm, 1);
    $display("done wake");
  endtask : t_wake

  task automatic t_intr;
    pkt.cfg[8:7] <= OWL_MODE_INTR;
    wait_line(1'h1, SC + 20);
    check("raise", dpin, 2'h3);
    i_host.drv(1'h0, 1'h1, FC);
    i_host.read(4, v);
    check("bits", v[3:0], pkt[39:36]);
    pkt.cfg[8:7] <= OWL_MODE_RSVD;
    mark();
    i_host.hold_low(TC + 5);
    check("term", n_term - tm, 1);
    repeat (SC + 20) @(posedge clk);
    check("rsvd", line, 1'h0);
    $display("done intr");
  endtask : t_intr

  initial
  begin
    errors = 0;
    compares = 0;
    n_term = 0;
    n_full = 0;
    nrst = 1'h0;
    motion = 1'h0;
    pkt = '{in_range: 1'h1, adc: 14'h2A5C, cfg: 25'h0A5A15};
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    repeat (8) @(posedge clk);
    check("idle", dpin, 2'h0);
    t_forced_full();
    t_abort();
    t_wake();
    t_intr();
    end_of_test();
  end
endmodule : one_wire_sensor_readout_link_test
